// File: pkg/smtk_pkg.sv
// Constants, types and BCD helpers of the memory-mapped timekeeper
package smtk_pkg;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int         ADDR_W    = 15;
	localparam int         DATA_W    = 8;
	localparam int         MEM_DEPTH = 32768;
	localparam int         NUM_REGS  = 8;
	localparam logic [11:0] CLK_PAGE = 12'hFFF;

	// ************************************************************
	// Clock register indices (low three address bits)
	// ************************************************************
	localparam logic [2:0] IDX_CTRL  = 3'h0;
	localparam logic [2:0] IDX_SEC   = 3'h1;
	localparam logic [2:0] IDX_MIN   = 3'h2;
	localparam logic [2:0] IDX_HOUR  = 3'h3;
	localparam int         CTRL_WR_BIT = 7;
	localparam int         CTRL_RD_BIT = 6;
	localparam logic [7:0] CTRL_RST    = 8'h00;

	// Counter-owned bits per register; the rest behave as plain storage
	localparam logic [7:0] FIELD_MASK [NUM_REGS] = '{8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF};

	// ************************************************************
	// BCD limits
	// ************************************************************
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE  = 8'h01;
	localparam logic [7:0] SEC_MAX  = 8'h59;
	localparam logic [7:0] MIN_MAX  = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] DAY_MAX  = 8'h07;
	localparam logic [7:0] MON_MAX  = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;

	// ************************************************************
	// Timebase
	// ************************************************************
	localparam int CLK_KHZ     = 40000;
	localparam int ONE_SEC_MS  = 1000;
	localparam int SEC_CYCLES  = CLK_KHZ * ONE_SEC_MS;
	localparam int PRESC_W     = 26;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic              pwr_ok;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} smtk_bus_t;

	localparam smtk_bus_t BUS_IDLE = '{pwr_ok: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000,
		data: 8'h00};

	// Seconds lowest so that register index i sits at bits (i-1)*8
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} smtk_time_t;

	localparam smtk_time_t RST_TIME = '{year: 8'h00, month: 8'h01, date: 8'h01, day: 8'h01,
		hour: 8'h00, min: 8'h00, sec: 8'h00};

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Two-digit year: 00 is 2000, a leap year; good through 2099
	function automatic logic is_leap(input logic [7:0] yr);
		return yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
		             : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] days_in_month(input logic [7:0] mo, input logic [7:0] yr);
		case (mo)
			8'h02: return is_leap(yr) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// Out-of-range loaded values wrap at the next carry instead of sticking
	function automatic smtk_time_t advance(input smtk_time_t t);
		smtk_time_t n;
		n = t;
		if (t.sec < SEC_MAX) n.sec = bcd_inc(t.sec);
		else begin
			n.sec = BCD_ZERO;
			if (t.min < MIN_MAX) n.min = bcd_inc(t.min);
			else begin
				n.min = BCD_ZERO;
				if (t.hour < HOUR_MAX) n.hour = bcd_inc(t.hour);
				else begin
					n.hour = BCD_ZERO;
					n.day  = (t.day >= DAY_MAX) ? BCD_ONE : bcd_inc(t.day);
					if (t.date < days_in_month(t.month, t.year)) n.date = bcd_inc(t.date);
					else begin
						n.date = BCD_ONE;
						if (t.month < MON_MAX) n.month = bcd_inc(t.month);
						else begin
							n.month = BCD_ONE;
							n.year  = (t.year >= YEAR_MAX) ? BCD_ZERO : bcd_inc(t.year);
						end
					end
				end
			end
		end
		return n;
	endfunction

endpackage

// File: verilog/smtk_mem.sv
// Byte-wide storage array with registered read data
`timescale 1ns/1ps
module smtk_mem (
	input  wire logic                           clk,
	input  wire logic                           wr_en,
	input  wire logic [smtk_pkg::ADDR_W-1:0]    wr_addr,
	input  wire logic [smtk_pkg::DATA_W-1:0]    wr_data,
	input  wire logic [smtk_pkg::ADDR_W-1:0]    rd_addr,
	output      logic [smtk_pkg::DATA_W-1:0]    rd_data
);
	import smtk_pkg::*;

	// Nonvolatile contents: deliberately no reset
	logic [DATA_W-1:0] mem [MEM_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule

// File: verilog/smtk_top.sv
// Memory-mapped BCD timekeeper: 32K x 8 storage with clock registers on top
// Operation
// - Storage is 32768 bytes, read and written one byte at a time.
// - Eight highest addresses hold the clock registers instead of storage.
// - Clock registers use the same bus cycles as ordinary storage.
// - Year, month, date, day, hours, minutes, seconds kept as BCD, 24-hour.
// - Month lengths and leap years handled automatically through 2099.
// - Internal counters run separate from visible registers and never lose time.
// - Supply out of tolerance deselects device, ignores accesses, data lines released.
// - Read-halt bit 6 of control stops copying counters to visible registers.
// - Halt freezes visible registers at the time current when halt was set.
// - Clearing read-halt refreshes all visible registers together within a second.
// - Write-halt bit 7 of control also stops visible register updates.
// - Clearing write-halt loads host-written values into counters, the second restarts.
// - Read when chip select active, write enable inactive; output enable drives data.
// - Write while chip select and write enable active; address held stable.
`timescale 1ns/1ps
module smtk_top #(
	parameter int TICKS_PER_SEC = smtk_pkg::SEC_CYCLES
) (
	input  wire logic                           SYS_CLK,
	input  wire logic                           SRST,
	input  wire logic [smtk_pkg::ADDR_W-1:0]    BYTE_ADDRESS,
	input  wire logic                           CE_N,
	input  wire logic                           OE_N,
	input  wire logic                           WE_N,
	input  wire logic                           SUPPLY_OK,
	input  wire logic [smtk_pkg::DATA_W-1:0]    DATA_LINES_I,
	output      logic [smtk_pkg::DATA_W-1:0]    DATA_LINES_O,
	output      logic                           DATA_LINES_OE,
	output      logic                           POWER_FAIL_FLAG_N
);
	import smtk_pkg::*;

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	smtk_bus_t         meta_q;
	smtk_bus_t         sync_q;
	smtk_bus_t         pins;
	logic              pwr_ok;
	logic              rd_cond;
	logic              wr_raw;
	logic              wr_act_q;
	logic              commit;
	logic [ADDR_W-1:0] wa_q;
	logic [DATA_W-1:0] wd_q;
	logic              w_top;
	logic [2:0]        w_idx;

	assign pins = '{pwr_ok: SUPPLY_OK, ce_n: CE_N, oe_n: OE_N, we_n: WE_N, addr: BYTE_ADDRESS,
		data: DATA_LINES_I};

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			meta_q <= BUS_IDLE;
			sync_q <= BUS_IDLE;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	// ************************************************************
	// Access decode
	// ************************************************************
	// Supply loss gates read decode, write capture and commit; chip select itself is not gated
	assign pwr_ok  = sync_q.pwr_ok;
	assign rd_cond = pwr_ok && !sync_q.ce_n && sync_q.we_n && !sync_q.oe_n;
	assign wr_raw  = !sync_q.ce_n && !sync_q.we_n;
	// Data is taken at the end of the write, where it is guaranteed valid
	assign commit  = wr_act_q && !wr_raw && pwr_ok;
	assign w_top   = (wa_q[ADDR_W-1:3] == CLK_PAGE);
	assign w_idx   = wa_q[2:0];

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wr_act_q <= 1'b0;
			wa_q     <= '0;
			wd_q     <= '0;
		end else begin
			wr_act_q <= wr_raw && pwr_ok;
			if (wr_raw && pwr_ok) begin
				wa_q <= sync_q.addr;
				wd_q <= sync_q.data;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			POWER_FAIL_FLAG_N <= 1'b0;
		end else begin
			POWER_FAIL_FLAG_N <= pwr_ok;
		end
	end

	// ************************************************************
	// Storage array
	// ************************************************************
	logic [DATA_W-1:0] mem_rd;

	smtk_mem u_mem (
		.clk     (SYS_CLK),
		.wr_en   (commit && !w_top),
		.wr_addr (wa_q),
		.wr_data (wd_q),
		.rd_addr (sync_q.addr),
		.rd_data (mem_rd)
	);

	// ************************************************************
	// Timebase and internal counters
	// ************************************************************
	logic [PRESC_W-1:0] presc_q;
	logic               tick;
	smtk_time_t         cnt_q;
	smtk_time_t         load_val;
	logic [7:0]         vis_q [NUM_REGS];
	logic               halt;
	logic               wr_halt_prev_q;
	logic               load;

	assign tick = (presc_q == PRESC_W'(TICKS_PER_SEC - 1));
	assign halt = vis_q[IDX_CTRL][CTRL_RD_BIT] || vis_q[IDX_CTRL][CTRL_WR_BIT];
	assign load = wr_halt_prev_q && !vis_q[IDX_CTRL][CTRL_WR_BIT];

	always_comb begin
		load_val = cnt_q;
		for (int i = 1; i < NUM_REGS; i++) begin
			load_val[(i-1)*8 +: 8] = vis_q[i] & FIELD_MASK[i];
		end
	end

	// A load restarts the second so the set time is held a full second
	always_ff @(posedge SYS_CLK) begin
		if (SRST || load || tick) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + PRESC_W'(1);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wr_halt_prev_q <= 1'b0;
		end else begin
			wr_halt_prev_q <= vis_q[IDX_CTRL][CTRL_WR_BIT];
		end
	end

	// Counters never look at halt or bus traffic, only at a load
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cnt_q <= RST_TIME;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (tick) begin
			cnt_q <= advance(cnt_q);
		end
	end

	// ************************************************************
	// Visible clock registers
	// ************************************************************
	// A host write beats the counter copy in the same cycle; storage bits survive
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			vis_q[IDX_CTRL] <= CTRL_RST;
			for (int i = 1; i < NUM_REGS; i++) begin
				vis_q[i] <= RST_TIME[(i-1)*8 +: 8];
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (commit && w_top && w_idx == 3'(i)) begin
					vis_q[i] <= wd_q;
				end else if (i != 0 && !halt && !load) begin
					vis_q[i] <= (vis_q[i] & ~FIELD_MASK[i]) | (cnt_q[(i-1)*8 +: 8] & FIELD_MASK[i]);
				end
			end
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	logic       r_top_q;
	logic [2:0] r_idx_q;
	logic       r_oe_q;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			r_top_q       <= 1'b0;
			r_idx_q       <= '0;
			r_oe_q        <= 1'b0;
			DATA_LINES_O  <= '0;
			DATA_LINES_OE <= 1'b0;
		end else begin
			r_top_q       <= (sync_q.addr[ADDR_W-1:3] == CLK_PAGE);
			r_idx_q       <= sync_q.addr[2:0];
			r_oe_q        <= rd_cond;
			DATA_LINES_O  <= r_top_q ? vis_q[r_idx_q] : mem_rd;
			DATA_LINES_OE <= r_oe_q && rd_cond;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	AST_DESELECT: assert property (!pwr_ok [*3] |-> !DATA_LINES_OE)
		else $error("Data lines driven during supply fault");
	AST_FLAG: assert property (!pwr_ok |=> !POWER_FAIL_FLAG_N)
		else $error("Power fail flag not raised");
	AST_FREEZE: assert property (halt && !(commit && w_top && w_idx == IDX_SEC) |=> $stable(vis_q[IDX_SEC]))
		else $error("Visible seconds changed while halted");
	AST_REFRESH: assert property (!halt && !load && !commit |=> (vis_q[IDX_MIN] & FIELD_MASK[IDX_MIN]) == $past(cnt_q.min))
		else $error("Visible minutes not refreshed");
	AST_RUN: assert property (tick && !load |=> cnt_q.sec != $past(cnt_q.sec))
		else $error("Seconds did not advance on tick");
	AST_LOAD: assert property (load |=> cnt_q.hour == $past(vis_q[IDX_HOUR] & FIELD_MASK[IDX_HOUR]))
		else $error("Counters not loaded after write halt");
	AST_BCD: assert property (cnt_q.hour <= HOUR_MAX && cnt_q.sec[3:0] <= 4'h9)
		else $error("Counter outside BCD range");
	AST_DIM: assert property (cnt_q.date <= days_in_month(cnt_q.month, cnt_q.year))
		else $error("Date beyond month length");
	AST_CTRL_WR: assert property (commit && w_top && w_idx == IDX_CTRL |=> vis_q[IDX_CTRL] == $past(wd_q))
		else $error("Control write lost");
	AST_READ: assert property (DATA_LINES_OE |-> $past(rd_cond, 2) && $past(rd_cond))
		else $error("Data driven without read access");

endmodule

// File: bench/smtk_host.sv
// Host model: asynchronous memory bus master and supply monitor source
`timescale 1ns/1ps
module smtk_host (
	input  wire logic                        clk,
	output      logic [smtk_pkg::ADDR_W-1:0] addr,
	output      logic                        ce_n,
	output      logic                        oe_n,
	output      logic                        we_n,
	output      logic                        supply_ok,
	output      logic [smtk_pkg::DATA_W-1:0] data
);
	import smtk_pkg::*;

	// ************************************************************
	// Bus cycles
	// ************************************************************
	initial begin
		addr = 15'h0000;
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		supply_ok = 1'b1;
		data = 8'h00;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic power(input logic ok);
		supply_ok = ok;
	endtask

	// Levels held 4 cycles: the pins pass a 2-stage synchroniser
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr = a;
		data = d;
		ce_n = 1'b0;
		we_n = 1'b0;
		idle(4);
		we_n = 1'b1;
		ce_n = 1'b1;
		idle(1);
		data = ~d; // Released lines never keep the last value
		idle(3);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic oe);
		addr = a;
		ce_n = 1'b0;
		oe_n = ~oe;
		idle(6);
		ce_n = 1'b1;
		oe_n = 1'b1;
		idle(4);
	endtask
endmodule

// File: bench/tb_sram_mapped_timekeeper.sv
// Self-checking bench of the memory-mapped timekeeper
`timescale 1ns/1ps
module tb_sram_mapped_timekeeper;
	import smtk_pkg::*;

	// ************************************************************
	// Harness
	// ************************************************************
	logic                SYS_CLK;
	logic                SRST;
	logic [ADDR_W-1:0]   BYTE_ADDRESS;
	logic                CE_N;
	logic                OE_N;
	logic                WE_N;
	logic                SUPPLY_OK;
	logic [DATA_W-1:0]   DATA_LINES_I;
	logic [DATA_W-1:0]   DATA_LINES_O;
	logic                DATA_LINES_OE;
	logic                POWER_FAIL_FLAG_N;
	logic [7:0]          exp_q[$];
	int                  n_errors = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	logic                prev_oe = 1'b0;
	logic [15:0]         lfsr_v = 16'h0011;
	logic [ADDR_W-1:0]   am[6];
	logic [7:0]          dm[6];
	logic [7:0]          set_v[7] = '{8'h58, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00};
	logic [7:0]          now_v[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h00};

	smtk_top #(.TICKS_PER_SEC(20)) i_smtk_top (.SYS_CLK(SYS_CLK), .SRST(SRST), .BYTE_ADDRESS(BYTE_ADDRESS),
		.CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .SUPPLY_OK(SUPPLY_OK), .DATA_LINES_I(DATA_LINES_I),
		.DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE(DATA_LINES_OE), .POWER_FAIL_FLAG_N(POWER_FAIL_FLAG_N));
	smtk_host i_smtk_host (.clk(SYS_CLK), .addr(BYTE_ADDRESS), .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N),
		.supply_ok(SUPPLY_OK), .data(DATA_LINES_I));

	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_smtk_host.rd(a, 1'b1);
	endtask

	task automatic complete_run();
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Any drive with no note queued is a mismatch
	always @(negedge SYS_CLK) begin
		prev_oe <= DATA_LINES_OE;
		if (DATA_LINES_OE === 1'b1 && prev_oe !== 1'b1) begin
			if (exp_q.size() == 0) check("unexpected drive", 8'h00, 8'hFF);
			else check("read data", exp_q.pop_front(), DATA_LINES_O);
		end
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		SRST = 1'b1;
		repeat (8) @(posedge SYS_CLK);
		#2 SRST = 1'b0;
		i_smtk_host.idle(4);
		check("power flag", 8'h01, {7'h00, POWER_FAIL_FLAG_N});
		rd_exp(15'h7FF8, CTRL_RST);
		for (int i = 0; i < 6; i++) begin
			lfsr_v = lfsr(lfsr_v);
			am[i] = (i == 0) ? 15'h7FF7 : (i == 1) ? 15'h0000 : {1'b0, lfsr_v[13:0]};
			dm[i] = lfsr_v[15:8];
			i_smtk_host.wr(am[i], dm[i]);
		end
		for (int i = 0; i < 6; i++) rd_exp(am[i], dm[i]);
		// Load 2000-02-28 23:59:58, two ticks before a leap-day rollover
		i_smtk_host.wr(15'h7FF8, 8'h80);
		for (int i = 0; i < 7; i++) i_smtk_host.wr(15'(15'h7FF9 + i), set_v[i]);
		for (int i = 0; i < 7; i++) rd_exp(15'(15'h7FF9 + i), set_v[i]);
		i_smtk_host.wr(15'h7FF8, 8'h00);
		i_smtk_host.idle(45);
		i_smtk_host.wr(15'h7FF8, 8'h40);
		for (int i = 0; i < 7; i++) rd_exp(15'(15'h7FF9 + i), now_v[i]);
		i_smtk_host.idle(10);
		i_smtk_host.wr(15'h7FF8, 8'h00);
		i_smtk_host.wr(15'h7FF8, 8'h40);
		rd_exp(15'h7FF9, 8'h05);
		i_smtk_host.rd(am[2], 1'b0);
		i_smtk_host.power(1'b0);
		i_smtk_host.idle(4);
		check("power flag", 8'h00, {7'h00, POWER_FAIL_FLAG_N});
		i_smtk_host.rd(am[1], 1'b1);
		i_smtk_host.wr(am[1], ~dm[1]);
		i_smtk_host.power(1'b1);
		i_smtk_host.idle(4);
		rd_exp(am[1], dm[1]);
		i_smtk_host.idle(10);
		if (exp_q.size() != 0) check("pending reads", 8'h00, 8'(exp_q.size()));
		complete_run();
	end
endmodule
